//--- tb/bcs_ctrl_props.sv
// Purpose: port checks for the bridge tuning and downstream command block
// Assumes: straps stable outside reset
// Notes: bound to every bcs_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module bcs_ctrl_props #(
    parameter int RETRY_C0 = 1000
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // configuration access
    input wire bcs_pkg::bcs_cfg_req_t cfg_req,
    input wire bcs_pkg::bcs_cfg_rsp_t cfg_rsp,
    // straps
    input wire logic test_select_zero,
    input wire logic test_select_one,
    input wire logic test_select_two,
    input wire logic mask_input_strap,
    // events
    input wire logic retry_start,
    input wire logic sec_io_req,
    input wire logic parity_event,
    input wire logic error_event,
    input wire logic intx_req,
    // outputs watched
    input wire logic [15:0] discard_limit_r,
    input wire logic retry_expired_r,
    input wire logic loopback_r,
    input wire logic reverse_mode_r,
    input wire logic sec_io_claim_r,
    input wire logic mdpe_set_r,
    input wire logic serr_oe_r,
    input wire logic intx_assert_r
);
    import bcs_pkg::*;
    // cycles since the last retry start; the shortest code bounds any expiry
    logic [31:0] since_r;
    always_ff @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
            since_r <= 32'h0;
        else
            since_r <= retry_start ? 32'h1 : since_r + 32'h1;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    rsp_follows_a: assert property (cfg_req.valid |=> (cfg_rsp.done || cfg_rsp.crs || cfg_rsp.retry))
        else $error("config access not answered next cycle");
    crs_forward_a: assert property (cfg_rsp.crs |-> !reverse_mode_r && !$past(cfg_req.from_secondary) && cfg_rsp.rdata == 32'h0)
        else $error("bad crs answer");
    retry_reverse_a: assert property (cfg_rsp.retry |-> reverse_mode_r && !$past(cfg_req.from_secondary) && cfg_rsp.rdata == 32'h0)
        else $error("bad retry answer");
    io_claim_a: assert property (sec_io_claim_r |-> $past(sec_io_req))
        else $error("io claim without request");
    parity_flag_a: assert property (mdpe_set_r |-> $past(parity_event))
        else $error("parity flag without event");
    serr_reverse_a: assert property (serr_oe_r |-> $past(error_event) && reverse_mode_r)
        else $error("serr drive without cause");
    intx_release_a: assert property (intx_assert_r |-> $past(intx_req))
        else $error("intx held without request");
    loop_straps_a: assert property (loopback_r |-> reverse_mode_r && !test_select_zero && test_select_one && test_select_two && mask_input_strap)
        else $error("loopback with wrong straps");
    discard_len_a: assert property (discard_limit_r inside {16'h0040, 16'h0400, 16'h8000})
        else $error("discard length not a legal value");
    retry_early_a: assert property (retry_expired_r |-> since_r >= RETRY_C0 + 1)
        else $error("retry timer expired too early");
    lock_retry_c: cover property (cfg_rsp.retry);
    loop_on_c: cover property ($rose(loopback_r));
    retry_fire_c: cover property (retry_expired_r);
endmodule
bind bcs_ctrl bcs_ctrl_props #(.RETRY_C0(RETRY_C0)) bcs_ctrl_props_i (
    .sys_clk, .arst_n, .cfg_req, .cfg_rsp, .test_select_zero, .test_select_one,
    .test_select_two, .mask_input_strap, .retry_start, .sec_io_req, .parity_event,
    .error_event, .intx_req, .discard_limit_r, .retry_expired_r, .loopback_r,
    .reverse_mode_r, .sec_io_claim_r, .mdpe_set_r, .serr_oe_r, .intx_assert_r);
`default_nettype wire

//--- tb/bcs_ctrl_tb.sv
// Purpose: self-checking bench for the bridge control block
// Assumes: shortened timer counts
// Notes: config answers checked through a queue
`timescale 1ns/1ps
`default_nettype none
module bcs_ctrl_tb;
    import bcs_pkg::*;
    localparam int RC [4] = '{10, 20, 30, 40};
    localparam int CC [4] = '{15, 25, 35, 0};
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    bcs_cfg_req_t cfg_req = '0;
    bcs_cfg_rsp_t cfg_rsp;
    logic test_select_zero = 1'b0;
    logic test_select_one = 1'b1, test_select_two = 1'b1, mask_input_strap = 1'b1;
    logic direction_strap = 1'b1;
    logic fwd_discard_sel = 1'b0, rev_discard_sel = 1'b0;
    logic retry_start = 1'b0, retry_stop = 1'b0, cpl_start = 1'b0, cpl_stop = 1'b0;
    logic sec_io_req = 1'b0, sec_mem_rd_req = 1'b0, parity_event = 1'b0;
    logic error_event = 1'b0, intx_req = 1'b0;
    logic [15:0] discard_limit_r;
    logic [2:0] fwd_tc_r;
    logic retry_expired_r, cpl_expired_r, strict_order_r, loopback_r, reverse_mode_r;
    logic sec_io_claim_r, sec_mem_claim_r, sec_master_en_r, mdpe_set_r, err_msg_r;
    logic serr_o_r, serr_oe_r, intx_assert_r;
    int errors = 0, total_checks = 0, seed = 39640, rn, cn;
    logic [31:0] wd, kw;
    logic [34:0] expq [$];
    logic [34:0] e;

    bcs_ctrl #(.RETRY_C0(RC[0]), .RETRY_C1(RC[1]), .RETRY_C2(RC[2]), .RETRY_C3(RC[3]),
        .CPL_C0(CC[0]), .CPL_C1(CC[1]), .CPL_C2(CC[2])) bcs_ctrl_i (
        .sys_clk, .arst_n, .cfg_req, .cfg_rsp, .test_select_zero, .test_select_one,
        .test_select_two, .mask_input_strap, .direction_strap, .fwd_discard_sel,
        .rev_discard_sel, .retry_start, .retry_stop, .cpl_start, .cpl_stop, .sec_io_req,
        .sec_mem_rd_req, .parity_event, .error_event, .intx_req, .discard_limit_r,
        .retry_expired_r, .cpl_expired_r, .strict_order_r, .fwd_tc_r, .loopback_r,
        .reverse_mode_r, .sec_io_claim_r, .sec_mem_claim_r, .sec_master_en_r, .mdpe_set_r,
        .err_msg_r, .serr_o_r, .serr_oe_r, .intx_assert_r);

    always #12.5 sys_clk = ~sys_clk;

    task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // top note bit: compare read data; writes answer with data ignored
    task automatic acc(input logic sec, input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [33:0] x);
        cfg_req <= '{1'b1, sec, wr, a, 4'hF, d};
        expq.push_back({~wr, x});
        @(posedge sys_clk) #1;
        cfg_req.valid <= 1'b0;
        @(posedge sys_clk) #1;
    endtask

    task automatic ev(input logic [31:0] cmd);
        {sec_io_req, sec_mem_rd_req, parity_event, error_event, intx_req} <= 5'h1F;
        @(posedge sys_clk) #1;
        {sec_io_req, sec_mem_rd_req, parity_event, error_event, intx_req} <= 5'h00;
        chk("events", 34'({sec_io_claim_r, sec_mem_claim_r, sec_master_en_r, mdpe_set_r,
            err_msg_r, serr_oe_r, serr_o_r, intx_assert_r}), 34'({cmd[0] & cmd[2],
            cmd[1] & cmd[2], cmd[2], cmd[6], cmd[8] & ~direction_strap,
            cmd[8] & direction_strap, 1'b0, ~cmd[10]}));
    endtask

    always @(negedge sys_clk)
        if (cfg_rsp.done | cfg_rsp.crs | cfg_rsp.retry)
        begin
            e = (expq.size() > 0) ? expq.pop_front() : 35'h7_FFFF_FFFF;
            chk("answer", {cfg_rsp.crs, cfg_rsp.retry, e[34] ? cfg_rsp.rdata : 32'h0}, e[33:0]);
        end

    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        repeat (6) @(posedge sys_clk) #1;
        chk("reset outputs", 34'({discard_limit_r, fwd_tc_r, loopback_r, reverse_mode_r}),
            34'({16'h8000, 3'h0, 1'b0, 1'b1}));
        acc(1'b1, 1'b0, 8'h40, 32'h0, {2'b00, 32'h0920_0000});
        acc(1'b1, 1'b0, 8'h44, 32'h0, 34'h0);
        acc(1'b1, 1'b1, 8'h48, 32'hFFFF_FFFF, 34'h0);
        acc(1'b1, 1'b0, 8'h48, 32'h0, 34'h0);
        repeat (6)
        begin
            wd = $random(seed);
            acc(1'b1, 1'b1, 8'h44, wd, 34'h0);
            acc(1'b1, 1'b0, 8'h44, 32'h0, {2'b00, wd & 32'h0000_0547});
            ev(wd);
        end
        kw = wd;
        for (int c = 0; c < 4; c++)
        begin
            wd = {2'b00, 3'(c + 4), 1'b1, 2'(c), c[1], 2'(c), c[0], 20'h0};
            rev_discard_sel <= c[1];
            acc(1'b1, 1'b1, 8'h40, wd, 34'h0);
            acc(1'b1, 1'b0, 8'h40, 32'h0, {2'b00, wd});
            chk("tuning", 34'({discard_limit_r, strict_order_r, fwd_tc_r, loopback_r}),
                34'({c[0] ? 16'h0040 : (c[1] ? 16'h0400 : 16'h8000), c[1], 3'(c + 4),
                1'b0}));
            {retry_start, cpl_start} <= 2'b11;
            @(posedge sys_clk) #1;
            {retry_start, cpl_start} <= 2'b00;
            rn = 0;
            cn = 0;
            for (int k = 1; k < 60; k++)
            begin
                @(posedge sys_clk) #1;
                if (retry_expired_r === 1'b1) rn = k;
                if (cpl_expired_r === 1'b1) cn = k;
            end
            chk("retry time", 34'(rn), 34'(RC[c]));
            chk("cpl time", 34'(cn), 34'(CC[c]));
        end
        // a stop one cycle after start must keep the timer silent
        retry_start <= 1'b1;
        @(posedge sys_clk) #1;
        retry_start <= 1'b0;
        retry_stop <= 1'b1;
        @(posedge sys_clk) #1;
        retry_stop <= 1'b0;
        rn = 0;
        repeat (60)
        begin
            @(posedge sys_clk) #1;
            if (retry_expired_r === 1'b1) rn = 1;
        end
        chk("retry stop", 34'(rn), 34'h0);
        // lockout last: it shuts the primary side out
        acc(1'b1, 1'b1, 8'h40, 32'hFFFF_FFFF, 34'h0);
        acc(1'b1, 1'b0, 8'h40, 32'h0, {2'b00, 32'hFFF0_0000});
        chk("loopback", 34'({loopback_r, fwd_tc_r}), 34'h0F);
        acc(1'b0, 1'b0, 8'h40, 32'h0, {2'b01, 32'h0});
        acc(1'b0, 1'b1, 8'h44, ~kw, {2'b01, 32'h0});
        acc(1'b1, 1'b0, 8'h44, 32'h0, {2'b00, kw & 32'h0000_0547});
        // second reset, forward mode with lockout strapped on
        arst_n <= 1'b0;
        {test_select_zero, direction_strap} <= 2'b10;
        repeat (3) @(posedge sys_clk) #1;
        arst_n <= 1'b1;
        repeat (6) @(posedge sys_clk) #1;
        acc(1'b0, 1'b0, 8'h40, 32'h0, {2'b10, 32'h0});
        acc(1'b1, 1'b1, 8'h40, 32'h4000_0000, 34'h0);
        acc(1'b1, 1'b0, 8'h40, 32'h0, 34'h0);
        {fwd_discard_sel, rev_discard_sel} <= 2'b10;
        acc(1'b1, 1'b1, 8'h44, 32'h0000_0107, 34'h0);
        chk("fwd discard", 34'({discard_limit_r, reverse_mode_r}), 34'({16'h0400, 1'b0}));
        ev(32'h0000_0107);
        test_done;
    end

    // whole run is near 400 cycles; allow far more
    initial
    begin
        #100000;
        errors++;
        test_done;
    end
endmodule
`default_nettype wire

//--- verilog/bcs_consts.svh
// Purpose: constants for the bridge tuning and downstream command registers
// Assumes: 40 MHz core clock
// Notes: included by bare name
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

`define BCS_OFF_TUNE 8'h40
`define BCS_OFF_CMD 8'h44

`define BCS_TUNE_RST 32'h0920_0000
`define BCS_TUNE_WMASK 32'hFFF0_0000
`define BCS_CMD_RST 16'h0000
`define BCS_CMD_WMASK 16'h0547

`define BCS_B_DSHORT 20
`define BCS_B_RETRY 21
`define BCS_B_ORDER 23
`define BCS_B_CPL 24
`define BCS_B_ISO 26
`define BCS_B_TC 27
`define BCS_B_LOOP 30
`define BCS_B_LOCK 31

`define BCS_C_IO 0
`define BCS_C_MEM 1
`define BCS_C_BME 2
`define BCS_C_PERR 6
`define BCS_C_SERR 8
`define BCS_C_INTD 10

`define BCS_TC_DEFAULT 3'h0
`define BCS_DISC_SHORT 16'h0040
`define BCS_DISC_MED 16'h0400
`define BCS_DISC_LONG 16'h8000

`define BCS_CLK_NS 25
`define BCS_RETRY0_NS 25000
`define BCS_RETRY1_NS 500000
`define BCS_RETRY2_NS 5000000
`define BCS_RETRY3_NS 25000000
`define BCS_CPL0_NS 50000
`define BCS_CPL1_NS 10000000
`define BCS_CPL2_NS 50000000
`define BCS_CPL_OFF 2'h3

`define BCS_STRAP_WAIT 2'h3

`endif

//--- verilog/bcs_ctrl.sv
// Purpose: bridge tuning control word (bits 31:20) and downstream command register
// Assumes: straps asynchronous; other inputs on sys_clk; request held one cycle
// Notes: configuration reachable from primary or secondary side
// Behaviour
// - short-duration bit set gives a 64 clock discard timer.
// - otherwise discard length comes from bridge control bit 24 forward, 25 reverse.
// - retry timer field: 25us, 0.5ms, 5ms, 25ms.
// - ordering bit 0 allows out-of-order delayed completions, 1 keeps order.
// - completion timer field: 50us, 10ms, 50ms, or disabled.
// - isochronous off maps forwarded memory traffic to class zero.
// - isochronous on uses the three-bit class field, reset 001.
// - loopback acts only with the right strap pattern.
// - loopback bit is read-only in forward mode.
// - lockout blocks primary config: CRS forward, retry reverse.
// - lockout resets to 0 when test select zero is low.
// - I/O enable gates secondary I/O responses.
// - memory enable gates secondary memory reads.
// - master enable gates mastering and responses on the secondary side.
// - special cycle enable reads 0.
// - write-and-invalidate enable reads 0.
// - palette snoop ignored, its enable reads 0.
// - parity response enables master data parity error reporting.
// - wait cycle control reads 0.
// - system error enable: messages forward, SERR reverse.
// - fast back-to-back enable reads 0.
// - interrupt disable stops and releases INTx.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_consts.svh"

module bcs_ctrl #(
    parameter int RETRY_C0 = `BCS_RETRY0_NS / `BCS_CLK_NS,
    parameter int RETRY_C1 = `BCS_RETRY1_NS / `BCS_CLK_NS,
    parameter int RETRY_C2 = `BCS_RETRY2_NS / `BCS_CLK_NS,
    parameter int RETRY_C3 = `BCS_RETRY3_NS / `BCS_CLK_NS,
    parameter int CPL_C0 = `BCS_CPL0_NS / `BCS_CLK_NS,
    parameter int CPL_C1 = `BCS_CPL1_NS / `BCS_CLK_NS,
    parameter int CPL_C2 = `BCS_CPL2_NS / `BCS_CLK_NS,
    parameter int TW = 21
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // configuration access
    input wire bcs_pkg::bcs_cfg_req_t cfg_req,
    output var bcs_pkg::bcs_cfg_rsp_t cfg_rsp,
    // straps, asynchronous
    input wire logic test_select_zero,
    input wire logic test_select_one,
    input wire logic test_select_two,
    input wire logic mask_input_strap,
    input wire logic direction_strap,
    // bridge control discard selects
    input wire logic fwd_discard_sel,
    input wire logic rev_discard_sel,
    // timer control
    input wire logic retry_start,
    input wire logic retry_stop,
    input wire logic cpl_start,
    input wire logic cpl_stop,
    // secondary events
    input wire logic sec_io_req,
    input wire logic sec_mem_rd_req,
    input wire logic parity_event,
    input wire logic error_event,
    input wire logic intx_req,
    // timing and policy
    output logic [15:0] discard_limit_r,
    output logic retry_expired_r,
    output logic cpl_expired_r,
    output logic strict_order_r,
    output logic [2:0] fwd_tc_r,
    output logic loopback_r,
    output logic reverse_mode_r,
    // secondary gating and reporting
    output logic sec_io_claim_r,
    output logic sec_mem_claim_r,
    output logic sec_master_en_r,
    output logic mdpe_set_r,
    output logic err_msg_r,
    output logic serr_o_r,
    output logic serr_oe_r,
    output logic intx_assert_r
);
    import bcs_pkg::*;

    logic [31:0] tune_r;
    logic [15:0] cmd_r;
    logic [4:0] strap_m_r;
    logic [4:0] strap_s_r;
    logic [1:0] wait_r;
    bcs_strap_st_t st_r;
    logic [TW-1:0] retry_cnt_r;
    logic retry_run_r;
    logic [TW-1:0] cpl_cnt_r;
    logic cpl_run_r;
    logic tsel0, tsel1, tsel2, msk, rev;
    logic locked_out;
    logic hit_tune, hit_cmd;
    logic [TW-1:0] retry_lim, cpl_lim;

    function automatic logic [31:0] bcs_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be,
                                              input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
        return (old & ~m) | (wd & m);
    endfunction

    function automatic logic [TW-1:0] bcs_pick(input logic [1:0] code,
                                               input int c0, input int c1,
                                               input int c2, input int c3);
        int v;
        v = c0;
        case (code)
            2'h1: v = c1;
            2'h2: v = c2;
            2'h3: v = c3;
            default: v = c0;
        endcase
        return TW'(v - 1);
    endfunction

    assign tsel0 = strap_s_r[0];
    assign tsel1 = strap_s_r[1];
    assign tsel2 = strap_s_r[2];
    assign msk = strap_s_r[3];
    assign rev = strap_s_r[4];

    // straps through two flops before use
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_m_r <= 5'h00;
            strap_s_r <= 5'h00;
        end
        else
        begin
            strap_m_r <= {direction_strap, mask_input_strap, test_select_two,
                          test_select_one, test_select_zero};
            strap_s_r <= strap_m_r;
        end
    end

    // strap capture waits for the synchroniser to settle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= BCS_ST_WAIT;
            wait_r <= 2'h0;
        end
        else
        begin
            unique case (st_r)
                BCS_ST_WAIT:
                begin
                    wait_r <= wait_r + 2'h1;
                    if (wait_r == `BCS_STRAP_WAIT)
                        st_r <= BCS_ST_SAMPLE;
                end
                BCS_ST_SAMPLE: st_r <= BCS_ST_RUN;
                BCS_ST_RUN: st_r <= BCS_ST_RUN;
                default: st_r <= BCS_ST_WAIT;
            endcase
        end
    end

    assign hit_tune = cfg_req.addr == `BCS_OFF_TUNE;
    assign hit_cmd = cfg_req.addr == `BCS_OFF_CMD;
    assign locked_out = tune_r[`BCS_B_LOCK] & ~cfg_req.from_secondary;

    // tuning control word
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            tune_r <= `BCS_TUNE_RST;
        else if (st_r == BCS_ST_SAMPLE)
            tune_r[`BCS_B_LOCK] <= tsel0;
        else if (cfg_req.valid && cfg_req.write && hit_tune && !locked_out)
        begin
            // loopback bit is frozen for a forward bridge
            tune_r <= bcs_merge(tune_r, cfg_req.wdata, cfg_req.be,
                                `BCS_TUNE_WMASK & ~({31'h0, ~rev} << `BCS_B_LOOP));
        end
    end

    // downstream command, read-only bits never take a write
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cmd_r <= `BCS_CMD_RST;
        else if (cfg_req.valid && cfg_req.write && hit_cmd && !locked_out)
            cmd_r <= 16'(bcs_merge({16'h0, cmd_r}, cfg_req.wdata, cfg_req.be,
                                   {16'h0, `BCS_CMD_WMASK}));
    end

    // configuration answer, one cycle after the request
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cfg_rsp <= '0;
        else
        begin
            cfg_rsp.done <= cfg_req.valid;
            cfg_rsp.crs <= cfg_req.valid & locked_out & ~rev;
            cfg_rsp.retry <= cfg_req.valid & locked_out & rev;
            cfg_rsp.rdata <= 32'h0;
            if (cfg_req.valid && !cfg_req.write && !locked_out)
            begin
                if (hit_tune)
                    cfg_rsp.rdata <= tune_r & `BCS_TUNE_WMASK;
                else if (hit_cmd)
                    cfg_rsp.rdata <= {16'h0, cmd_r & `BCS_CMD_WMASK};
            end
        end
    end

    // policy outputs
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            discard_limit_r <= `BCS_DISC_LONG;
            strict_order_r <= 1'b0;
            fwd_tc_r <= `BCS_TC_DEFAULT;
            loopback_r <= 1'b0;
            reverse_mode_r <= 1'b0;
        end
        else
        begin
            if (tune_r[`BCS_B_DSHORT])
                discard_limit_r <= `BCS_DISC_SHORT;
            else if (rev ? rev_discard_sel : fwd_discard_sel)
                discard_limit_r <= `BCS_DISC_MED;
            else
                discard_limit_r <= `BCS_DISC_LONG;
            strict_order_r <= tune_r[`BCS_B_ORDER];
            fwd_tc_r <= tune_r[`BCS_B_ISO] ? tune_r[`BCS_B_TC +: 3]
                                           : `BCS_TC_DEFAULT;
            loopback_r <= tune_r[`BCS_B_LOOP] & ~tsel0 & tsel1 & tsel2 & msk & rev;
            reverse_mode_r <= rev;
        end
    end

    assign retry_lim = bcs_pick(tune_r[`BCS_B_RETRY +: 2],
                                RETRY_C0, RETRY_C1, RETRY_C2, RETRY_C3);
    assign cpl_lim = bcs_pick(tune_r[`BCS_B_CPL +: 2], CPL_C0, CPL_C1, CPL_C2, CPL_C2);

    // configuration retry timer, one pulse at expiry
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            retry_cnt_r <= '0;
            retry_run_r <= 1'b0;
            retry_expired_r <= 1'b0;
        end
        else
        begin
            retry_expired_r <= 1'b0;
            if (retry_start)
            begin
                retry_cnt_r <= '0;
                retry_run_r <= 1'b1;
            end
            else if (retry_stop)
                retry_run_r <= 1'b0;
            else if (retry_run_r && retry_cnt_r >= retry_lim)
            begin
                retry_run_r <= 1'b0;
                retry_expired_r <= 1'b1;
            end
            else if (retry_run_r)
                retry_cnt_r <= retry_cnt_r + TW'(1);
        end
    end

    // completion timer; code 3 holds it idle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cpl_cnt_r <= '0;
            cpl_run_r <= 1'b0;
            cpl_expired_r <= 1'b0;
        end
        else
        begin
            cpl_expired_r <= 1'b0;
            if (tune_r[`BCS_B_CPL +: 2] == `BCS_CPL_OFF)
                cpl_run_r <= 1'b0;
            else if (cpl_start)
            begin
                cpl_cnt_r <= '0;
                cpl_run_r <= 1'b1;
            end
            else if (cpl_stop)
                cpl_run_r <= 1'b0;
            else if (cpl_run_r && cpl_cnt_r >= cpl_lim)
            begin
                cpl_run_r <= 1'b0;
                cpl_expired_r <= 1'b1;
            end
            else if (cpl_run_r)
                cpl_cnt_r <= cpl_cnt_r + TW'(1);
        end
    end

    // secondary gating; palette snoops are never claimed
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sec_io_claim_r <= 1'b0;
            sec_mem_claim_r <= 1'b0;
            sec_master_en_r <= 1'b0;
        end
        else
        begin
            sec_io_claim_r <= sec_io_req & cmd_r[`BCS_C_IO] & cmd_r[`BCS_C_BME];
            sec_mem_claim_r <= sec_mem_rd_req & cmd_r[`BCS_C_MEM]
                               & cmd_r[`BCS_C_BME];
            sec_master_en_r <= cmd_r[`BCS_C_BME];
        end
    end

    // error reporting; SERR is open drain, driven low only
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mdpe_set_r <= 1'b0;
            err_msg_r <= 1'b0;
            serr_o_r <= 1'b0;
            serr_oe_r <= 1'b0;
            intx_assert_r <= 1'b0;
        end
        else
        begin
            mdpe_set_r <= parity_event & cmd_r[`BCS_C_PERR];
            err_msg_r <= error_event & cmd_r[`BCS_C_SERR] & ~rev;
            serr_o_r <= 1'b0;
            serr_oe_r <= error_event & cmd_r[`BCS_C_SERR] & rev;
            intx_assert_r <= intx_req & ~cmd_r[`BCS_C_INTD];
        end
    end

endmodule

`default_nettype wire

//--- verilog/bcs_pkg.sv
// Purpose: shared types of the bridge control block
// Assumes: nothing
// Notes: carrier structs for configuration access
package bcs_pkg;

    typedef struct packed {
        logic valid;
        logic from_secondary;
        logic write;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bcs_cfg_req_t;

    typedef struct packed {
        logic done;
        logic crs;
        logic retry;
        logic [31:0] rdata;
    } bcs_cfg_rsp_t;

    typedef enum logic [1:0] {
        BCS_ST_WAIT = 2'b00,
        BCS_ST_SAMPLE = 2'b01,
        BCS_ST_RUN = 2'b10
    } bcs_strap_st_t;

endpackage
